//--- design/cfg_bank_pkg.sv
// constants for configuration registers 16h to 21h
package cfg_bank_pkg;
    localparam logic [7:0] IDX_FIFO_SHADOW = 8'h16;
    localparam logic [7:0] IDX_VEND_A = 8'h17;
    localparam logic [7:0] IDX_RSVD_LO = 8'h18;
    localparam logic [7:0] IDX_RSVD_HI = 8'h1e;
    localparam logic [7:0] IDX_VEND_B = 8'h1f;
    localparam logic [7:0] IDX_VEND_C = 8'h20;
    localparam logic [7:0] IDX_TMO_SEL = 8'h21;
    localparam logic [7:0] RST_FIFO_SHADOW = 8'h00;
    localparam logic [7:0] RST_VEND_A = 8'h03;
    localparam logic [7:0] RST_RSVD = 8'h00;
    localparam logic [7:0] RST_VEND_B = 8'h00;
    localparam logic [7:0] RST_VEND_C = 8'h3c;
    localparam logic [7:0] RST_TMO_SEL = 8'h00;
    localparam logic [7:0] MASK_FIFO_SHADOW = 8'hcf;
    localparam logic [7:0] MASK_VEND_A = 8'h07;
    localparam logic [7:0] MASK_VEND_B = 8'hff;
    localparam logic [7:0] MASK_VEND_C = 8'hfc;
    localparam logic [7:0] MASK_TMO_SEL = 8'h07;
    localparam int FCR_FIFO_EN = 0;
    localparam int FCR_RX_RST = 1;
    localparam int FCR_TX_RST = 2;
    localparam int FCR_DMA_SEL = 3;
    localparam int FCR_TRIG_LO = 6;
    localparam int TMO_SEL_BIT = 2;
    localparam int EPP_TMO_BIT = 0;
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;
endpackage

//--- design/cfg_rw_field.sv
// one storage register with write mask and reset value
`timescale 1ns/100ps
`default_nettype none
module cfg_rw_field #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_value
);
    typedef struct packed {
        logic [7:0] value;
    } field_state_t;

    field_state_t state_r;
    field_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        if (i_wr)
        begin
            state_nxt.value = i_wdata & WR_MASK;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            state_r.value <= RST_VAL & WR_MASK;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign o_value = state_r.value;
endmodule
`default_nettype wire

//--- design/config_regs_16_to_21.sv
// configuration register bank slice, indices 16h through 21h
// Operation
// - access only in config state, matching index
// - 16h mirrors second serial port FIFO control
// - 17h resets 03h, bits 3-7 zero
// - 18h-1Eh ignore writes, read zero
// - 1Fh full read/write, resets 00h
// - 20h resets 3Ch, bits 0-1 zero
// - select zero: status read end clears timeout
// - select one: write one clears timeout
// - 21h bits 3-7 zero, resets zero
// - FIFO control bits 7:6 pick trigger level
// - FIFO reset bits empty FIFO, self clear
`timescale 1ns/100ps
`default_nettype none
module config_regs_16_to_21
    import cfg_bank_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_cfg_mode,
    input wire logic [7:0] i_config_index_reg,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_wdata,
    input wire logic i_fifo_ctrl_wr,
    input wire logic [7:0] i_fifo_ctrl_wdata,
    input wire logic i_epp_tmo_event,
    input wire logic i_epp_status_rd,
    input wire logic i_epp_status_wr,
    input wire logic [7:0] i_epp_status_wdata,
    output logic [7:0] o_cfg_rdata,
    output logic o_cfg_hit,
    output logic o_fifo_enable,
    output logic o_rx_fifo_reset,
    output logic o_tx_fifo_reset,
    output logic o_dma_mode_sel,
    output logic [4:0] o_rx_trigger_level,
    output logic o_epp_timeout,
    output logic o_tmo_clear_mode,
    output logic [7:0] o_vendor_a,
    output logic [7:0] o_vendor_b,
    output logic [7:0] o_vendor_c
);
    // shadow, reset pulses, timeout flag and registered read port
    typedef struct packed {
        logic [7:0] fifo_ctrl_reg;
        logic rx_rst;
        logic tx_rst;
        logic epp_tmo;
        logic stat_rd_d;
        logic [7:0] rdata;
        logic hit;
    } bank_state_t;

    bank_state_t state_r;
    bank_state_t state_nxt;

    logic sel_16;
    logic sel_17;
    logic sel_1f;
    logic sel_20;
    logic sel_21;
    logic sel_rsvd;
    logic [7:0] vend_a;
    logic [7:0] vend_b;
    logic [7:0] vend_c;
    logic [7:0] tmo_sel;
    logic [7:0] shadow_wdata;
    logic shadow_wr;
    // write strobes, clear conditions and read path
    logic wr_17;
    logic wr_1f;
    logic wr_20;
    logic wr_21;
    logic any_sel;
    logic tmo_rd_clr;
    logic tmo_wr_clr;
    logic [7:0] rd_mux;
    logic [7:0] shadow_masked;

    // index decode, gated by configuration state
    always_comb
    begin
        sel_16 = 1'b0;
        sel_17 = 1'b0;
        sel_1f = 1'b0;
        sel_20 = 1'b0;
        sel_21 = 1'b0;
        sel_rsvd = 1'b0;
        if (!i_cfg_mode)
        begin
            sel_16 = 1'b0;
        end
        else if (i_config_index_reg == IDX_FIFO_SHADOW)
        begin
            sel_16 = 1'b1;
        end
        else if (i_config_index_reg == IDX_VEND_A)
        begin
            sel_17 = 1'b1;
        end
        else if (i_config_index_reg >= IDX_RSVD_LO && i_config_index_reg <= IDX_RSVD_HI)
        begin
            sel_rsvd = 1'b1;
        end
        else if (i_config_index_reg == IDX_VEND_B)
        begin
            sel_1f = 1'b1;
        end
        else if (i_config_index_reg == IDX_VEND_C)
        begin
            sel_20 = 1'b1;
        end
        else if (i_config_index_reg == IDX_TMO_SEL)
        begin
            sel_21 = 1'b1;
        end
    end

    // config write strobes; the reserved range has none, so writes drop
    always_comb
    begin
        wr_17 = sel_17 && i_cfg_wr;
        wr_1f = sel_1f && i_cfg_wr;
        wr_20 = sel_20 && i_cfg_wr;
        wr_21 = sel_21 && i_cfg_wr;
    end

    assign any_sel = sel_16 || sel_17 || sel_rsvd || sel_1f || sel_20 || sel_21;

    // run-time FIFO control write takes priority over config write
    assign shadow_wr = i_fifo_ctrl_wr || (sel_16 && i_cfg_wr);
    assign shadow_wdata = i_fifo_ctrl_wr ? i_fifo_ctrl_wdata : i_cfg_wdata;

    // reset bits pulse once and never sit in the shadow
    always_comb
    begin
        shadow_masked = shadow_wdata & MASK_FIFO_SHADOW;
        shadow_masked[FCR_RX_RST] = 1'b0;
        shadow_masked[FCR_TX_RST] = 1'b0;
    end

    // trailing edge of a status read: strobe seen last cycle, gone now
    assign tmo_rd_clr = !tmo_sel[TMO_SEL_BIT] && state_r.stat_rd_d
        && !i_epp_status_rd;
    assign tmo_wr_clr = tmo_sel[TMO_SEL_BIT] && i_epp_status_wr
        && i_epp_status_wdata[EPP_TMO_BIT];

    // read mux; reserved range and no selection read zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (sel_16)
        begin
            rd_mux = state_r.fifo_ctrl_reg;
        end
        else if (sel_17)
        begin
            rd_mux = vend_a & MASK_VEND_A;
        end
        else if (sel_rsvd)
        begin
            rd_mux = 8'h00;
        end
        else if (sel_1f)
        begin
            rd_mux = vend_b;
        end
        else if (sel_20)
        begin
            rd_mux = vend_c & MASK_VEND_C;
        end
        else if (sel_21)
        begin
            rd_mux = tmo_sel & MASK_TMO_SEL;
        end
    end

    cfg_rw_field #(.RST_VAL(RST_VEND_A), .WR_MASK(MASK_VEND_A)) u_vend_a (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_wr(wr_17),
        .i_wdata(i_cfg_wdata),
        .o_value(vend_a)
    );

    cfg_rw_field #(.RST_VAL(RST_VEND_B), .WR_MASK(MASK_VEND_B)) u_vend_b (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_wr(wr_1f),
        .i_wdata(i_cfg_wdata),
        .o_value(vend_b)
    );

    cfg_rw_field #(.RST_VAL(RST_VEND_C), .WR_MASK(MASK_VEND_C)) u_vend_c (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_wr(wr_20),
        .i_wdata(i_cfg_wdata),
        .o_value(vend_c)
    );

    cfg_rw_field #(.RST_VAL(RST_TMO_SEL), .WR_MASK(MASK_TMO_SEL)) u_tmo_sel (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_wr(wr_21),
        .i_wdata(i_cfg_wdata),
        .o_value(tmo_sel)
    );

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.rx_rst = 1'b0;
        state_nxt.tx_rst = 1'b0;
        if (shadow_wr)
        begin
            state_nxt.fifo_ctrl_reg = shadow_masked;
            state_nxt.rx_rst = shadow_wdata[FCR_RX_RST];
            state_nxt.tx_rst = shadow_wdata[FCR_TX_RST];
        end
        // timeout flag: trailing edge of status read, or write of one
        state_nxt.stat_rd_d = i_epp_status_rd;
        if (tmo_rd_clr)
        begin
            state_nxt.epp_tmo = 1'b0;
        end
        if (tmo_wr_clr)
        begin
            state_nxt.epp_tmo = 1'b0;
        end
        if (i_epp_tmo_event)
        begin
            state_nxt.epp_tmo = 1'b1;
        end
        // read data and hit registered, zero without a read
        state_nxt.hit = i_cfg_rd && any_sel;
        state_nxt.rdata = 8'h00;
        if (i_cfg_rd)
        begin
            state_nxt.rdata = rd_mux;
        end
    end

    // sync reset loads the power-on defaults
    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            state_r.fifo_ctrl_reg <= RST_FIFO_SHADOW;
            state_r.rx_rst <= 1'b0;
            state_r.tx_rst <= 1'b0;
            state_r.epp_tmo <= 1'b0;
            state_r.stat_rd_d <= 1'b0;
            state_r.rdata <= RST_RSVD;
            state_r.hit <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // trigger level decode
    always_comb
    begin
        case (state_r.fifo_ctrl_reg[FCR_TRIG_LO +: 2])
            2'b00:
            begin
                o_rx_trigger_level = TRIG_1;
            end
            2'b01:
            begin
                o_rx_trigger_level = TRIG_4;
            end
            2'b10:
            begin
                o_rx_trigger_level = TRIG_8;
            end
            default:
            begin
                o_rx_trigger_level = TRIG_14;
            end
        endcase
    end

    // read port, shadow fields, timeout flag and config registers drive the outputs
    assign o_cfg_rdata = state_r.rdata;
    assign o_cfg_hit = state_r.hit;
    assign o_fifo_enable = state_r.fifo_ctrl_reg[FCR_FIFO_EN];
    assign o_rx_fifo_reset = state_r.rx_rst;
    assign o_tx_fifo_reset = state_r.tx_rst;
    assign o_dma_mode_sel = state_r.fifo_ctrl_reg[FCR_DMA_SEL];
    assign o_epp_timeout = state_r.epp_tmo;
    assign o_tmo_clear_mode = tmo_sel[TMO_SEL_BIT];
    assign o_vendor_a = vend_a;
    assign o_vendor_b = vend_b;
    assign o_vendor_c = vend_c;
endmodule
`default_nettype wire

//--- test/cfg_host_model.sv
// host model driving the configuration index and data ports
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    output logic o_mode,
    output logic [7:0] o_idx,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    initial {o_mode, o_idx, o_wr, o_rd, o_wdata} = '0;
    // one access; read data is taken one cycle after the strobe
    task automatic xfer(input logic m, w, input logic [7:0] i, d, output logic [7:0] q);
        @(negedge i_ref_clk);
        {o_mode, o_idx, o_wdata, o_wr, o_rd} = {m, i, d, w, !w};
        @(negedge i_ref_clk);
        q = i_rdata;
        {o_wr, o_rd, o_wdata} = {2'b00, ~d};
    endtask
endmodule
`default_nettype wire

//--- test/cfg_bank_asserts.sv
// assertions for the configuration register slice
`timescale 1ns/100ps
`default_nettype none
module cfg_bank_asserts
    import cfg_bank_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_cfg_mode,
    input wire logic [7:0] i_config_index_reg,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_wdata,
    input wire logic i_fifo_ctrl_wr,
    input wire logic [7:0] i_fifo_ctrl_wdata,
    input wire logic i_epp_tmo_event,
    input wire logic i_epp_status_rd,
    input wire logic i_epp_status_wr,
    input wire logic [7:0] i_epp_status_wdata,
    input wire logic [7:0] o_cfg_rdata,
    input wire logic o_cfg_hit,
    input wire logic o_rx_fifo_reset,
    input wire logic [4:0] o_rx_trigger_level,
    input wire logic o_epp_timeout,
    input wire logic o_tmo_clear_mode,
    input wire logic [7:0] o_vendor_a
);
    localparam logic [4:0] TRIG_TAB [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    logic [7:0] idx;
    logic rd_on;
    logic [4:0] trig_exp;
    assign idx = i_config_index_reg;
    assign rd_on = i_cfg_mode && i_cfg_rd;
    assign trig_exp = TRIG_TAB[i_fifo_ctrl_wdata[7:6]];
    a_read_hit: assert property (rd_on && idx == IDX_VEND_A
        |=> o_cfg_hit && o_cfg_rdata == $past(o_vendor_a)) else $error("bad read");
    a_closed_read: assert property (!i_cfg_mode && i_cfg_rd
        |=> !o_cfg_hit && o_cfg_rdata == 8'h00) else $error("closed read");
    a_rsvd_read: assert property (rd_on && idx inside {[IDX_RSVD_LO:IDX_RSVD_HI]}
        |=> o_cfg_rdata == 8'h00) else $error("reserved read");
    a_vend_a_wr: assert property (i_cfg_mode && i_cfg_wr && idx == IDX_VEND_A
        |=> o_vendor_a == ($past(i_cfg_wdata) & 8'h07)) else $error("vendor a");
    a_trig_map: assert property (i_fifo_ctrl_wr
        |=> o_rx_trigger_level == $past(trig_exp)) else $error("trigger level");
    a_rx_rst_pulse: assert property (i_fifo_ctrl_wr && i_fifo_ctrl_wdata[1]
        |=> o_rx_fifo_reset ##1 !o_rx_fifo_reset) else $error("fifo reset");
    a_tmo_rd_clr: assert property (!o_tmo_clear_mode && $fell(i_epp_status_rd)
        && !i_epp_tmo_event |=> !o_epp_timeout) else $error("timeout read");
    a_tmo_wr_clr: assert property (o_tmo_clear_mode && i_epp_status_wr
        && i_epp_status_wdata[0] && !i_epp_tmo_event |=> !o_epp_timeout) else $error("timeout wr");
    c_fifo: cover property (i_fifo_ctrl_wr);
    c_tmo_rd: cover property (!o_tmo_clear_mode && $fell(i_epp_status_rd));
    c_tmo_wr: cover property (o_tmo_clear_mode && i_epp_status_wr);
endmodule
bind config_regs_16_to_21 cfg_bank_asserts i_chk (.i_ref_clk, .i_reset, .i_cfg_mode,
    .i_config_index_reg, .i_cfg_wr, .i_cfg_rd, .i_cfg_wdata, .i_fifo_ctrl_wr,
    .i_fifo_ctrl_wdata, .i_epp_tmo_event, .i_epp_status_rd, .i_epp_status_wr,
    .i_epp_status_wdata, .o_cfg_rdata, .o_cfg_hit, .o_rx_fifo_reset, .o_rx_trigger_level,
    .o_epp_timeout, .o_tmo_clear_mode, .o_vendor_a);
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the configuration register slice
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cfg_bank_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode, wr, rd, fwr, ev, srd, swr, hit, fen, rxr, txr, tmo, tsel, dma;
    logic [7:0] idx, wd, fwd, swd, rdata, q, va, vb, vc;
    logic [4:0] trig;
    logic [7:0] rst_tab [12] = '{8'h00, 8'h03, '0, '0, '0, '0, '0, '0, '0, 8'h00, 8'h3c, 8'h00};
    logic [7:0] msk_tab [12] = '{8'hc9, 8'h07, '0, '0, '0, '0, '0, '0, '0, 8'hff, 8'hfc, 8'h07};
    logic [7:0] pat [3] = '{8'hff, 8'h5a, 8'h00};
    logic [4:0] trg [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    int num_errors = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    config_regs_16_to_21 i_config_regs_16_to_21 (.i_ref_clk(clk), .i_reset(rst),
        .i_cfg_mode(mode), .i_config_index_reg(idx), .i_cfg_wr(wr), .i_cfg_rd(rd),
        .i_cfg_wdata(wd), .i_fifo_ctrl_wr(fwr), .i_fifo_ctrl_wdata(fwd), .i_epp_tmo_event(ev),
        .i_epp_status_rd(srd), .i_epp_status_wr(swr), .i_epp_status_wdata(swd),
        .o_cfg_rdata(rdata), .o_cfg_hit(hit), .o_fifo_enable(fen), .o_rx_fifo_reset(rxr),
        .o_tx_fifo_reset(txr), .o_dma_mode_sel(dma), .o_rx_trigger_level(trig),
        .o_epp_timeout(tmo), .o_tmo_clear_mode(tsel), .o_vendor_a(va), .o_vendor_b(vb),
        .o_vendor_c(vc));
    cfg_host_model i_cfg_host_model (.i_ref_clk(clk), .i_rdata(rdata), .o_mode(mode),
        .o_idx(idx), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
    task automatic chk(input logic [7:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cfg(input logic m, w, input logic [7:0] i, d, e);
        i_cfg_host_model.xfer(m, w, i, d, q);
        if (!w)
        begin
            chk(q, e);
            chk(8'(hit), 8'(m));
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        {fwr, ev, srd, swr, fwd, swd} = '0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 12; k++)
            cfg(1, 0, 8'h16 + 8'(k), '0, rst_tab[k]);
        for (int p = 0; p < 3; p++)
        begin
            // last pass writes the reset defaults back to every index
            for (int k = 0; k < 12; k++)
                cfg(1, 1, 8'h16 + 8'(k), p == 2 ? rst_tab[k] : pat[p], '0);
            chk(va, p == 2 ? rst_tab[1] : pat[p] & msk_tab[1]);
            chk(vb, p == 2 ? rst_tab[9] : pat[p] & msk_tab[9]);
            chk(vc, p == 2 ? rst_tab[10] : pat[p] & msk_tab[10]);
            for (int k = 0; k < 12; k++)
                cfg(1, 0, 8'h16 + 8'(k), '0, p == 2 ? rst_tab[k] : pat[p] & msk_tab[k]);
        end
        cfg(0, 1, IDX_VEND_A, 8'h04, '0);
        cfg(0, 0, IDX_VEND_A, '0, '0);
        cfg(1, 0, IDX_VEND_A, '0, 8'h03);
        for (int k = 0; k < 4; k++)
        begin
            {fwr, fwd} = {1'b1, 2'(k), 2'h0, k[0], 3'h7};
            @(negedge clk);
            fwr = 1'b0;
            chk(8'({dma, rxr, txr, fen}), {4'h0, k[0], 3'h7});
            chk(8'(trig), 8'(trg[k]));
            @(negedge clk);
            chk(8'({dma, rxr, txr}), {5'h00, k[0], 2'h0});
            cfg(1, 0, IDX_FIFO_SHADOW, '0, {2'(k), 2'h0, k[0], 3'h1});
        end
        for (int m = 0; m < 2; m++)
        begin
            cfg(1, 1, IDX_TMO_SEL, 8'(m * 4), '0);
            chk(8'(tsel), 8'(m));
            ev = 1'b1;
            @(negedge clk);
            {ev, srd} = 2'b01;
            repeat (2) @(negedge clk);
            srd = 1'b0;
            @(negedge clk);
            chk(8'(tmo), 8'(m));
            {swr, swd} = {1'b1, 8'h01};
            @(negedge clk);
            swr = 1'b0;
            @(negedge clk);
            chk(8'(tmo), 8'h00);
        end
        end_of_test();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
